// ### hw/sdcba_top.sv
// Command decoder, bank state, clock-enable modes and data path of the SDRAM device.
`timescale 1ns/1ps
`default_nettype none


// ****************************************
// Write data FIFO
// ****************************************
module sdcba_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Filling side.
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // Draining side.
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0] count;
   } sdcba_fifo_state_t;

   sdcba_fifo_state_t s;
   sdcba_fifo_state_t next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready_out = (s.count != FULL_COUNT);
   assign out_valid_out = (s.count != '0);
   assign out_data_out = mem[s.rd_ptr];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // Pointers wrap naturally, so DEPTH is kept a power of two.
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.wr_ptr = PW'(s.wr_ptr + 1'b1);
      end
      if (pop) begin
         next_s.rd_ptr = PW'(s.rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         next_s.count = (PW + 1)'(s.count + 1'b1);
      end else if (pop && !push) begin
         next_s.count = (PW + 1)'(s.count - 1'b1);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[s.wr_ptr] <= in_data_in;
      end
   end
endmodule // sdcba_fifo

// ****************************************
// Device top
// ****************************************
module sdcba_top (
   // Clock and reset.
   input wire logic MCLK_IN,
   input wire logic RST_B_IN,
   // Command and address pins.
   input wire logic CLOCK_EN_IN,
   input wire logic CHIP_SEL_B_IN,
   input wire logic ROW_STROBE_B_IN,
   input wire logic COL_STROBE_B_IN,
   input wire logic WRITE_EN_B_IN,
   input wire logic [1:0] BANK_ADDRESS_IN,
   input wire logic [11:0] ADDR_IN,
   // Data lines and byte masks.
   input wire logic LOWER_BYTE_MASK_IN,
   input wire logic UPPER_BYTE_MASK_IN,
   input wire logic [15:0] DATA_LINES_IN,
   output logic [15:0] DATA_LINES_OUT,
   output logic [1:0] DATA_LINES_OE_OUT,
   // Status.
   output logic [3:0] BANK_ACTIVE_OUT,
   output logic [1:0] POWER_MODE_OUT,
   output logic BURST_BUSY_OUT,
   output logic CMD_REFUSED_OUT,
   output logic AUTO_REFRESH_OUT,
   output logic WRITE_READY_OUT
);
   localparam int WR_W = $bits(sdcba_pkg::sdcba_wr_t);

   typedef struct packed {
      logic cke_low_prev;
      sdcba_pkg::sdcba_pwr_t mode;
      sdcba_pkg::sdcba_bank_t [3:0] bank;
      logic [3:0][2:0] close_cnt;
      logic [3:0][11:0] open_row;
      logic [3:0] active_vec;
      logic [13:0] mode_reg;
      logic burst_on;
      logic burst_write;
      logic burst_ap;
      logic burst_full;
      logic [1:0] burst_bank;
      logic [7:0] burst_col;
      logic [7:0] burst_wrap;
      logic [7:0] beats_left;
      logic [1:0] pipe_valid;
      logic [1:0][9:0] pipe_idx;
      logic [1:0] mask_prev;
      logic [15:0] dq_out;
      logic [1:0] dq_oe;
      logic refused;
      logic refreshed;
      logic wr_ready;
   } sdcba_state_t;

   sdcba_state_t s;
   sdcba_state_t next_s;
   logic [15:0] mem [1024];
   sdcba_pkg::sdcba_cmd_t cmd;
   sdcba_pkg::sdcba_wr_t push_word;
   sdcba_pkg::sdcba_wr_t drain_word;
   logic push_valid;
   logic fifo_in_ready;
   logic drain_valid;
   logic drain_ready;
   logic cl3;
   logic load_valid;
   logic [9:0] load_idx;
   logic [15:0] load_word;

   function automatic sdcba_pkg::sdcba_cmd_t decode(input logic cs_b, input logic ras_b, input logic cas_b,
                                                    input logic we_b);
      sdcba_pkg::sdcba_cmd_t c;
      c = sdcba_pkg::CMD_NOP;
      if (cs_b) begin
         c = sdcba_pkg::CMD_DESELECT;
      end else begin
         case ({ras_b, cas_b, we_b})
            3'h3: c = sdcba_pkg::CMD_ACTIVATE;
            3'h2: c = sdcba_pkg::CMD_PRECHARGE;
            3'h5: c = sdcba_pkg::CMD_READ;
            3'h4: c = sdcba_pkg::CMD_WRITE;
            3'h0: c = sdcba_pkg::CMD_MODE_SET;
            3'h1: c = sdcba_pkg::CMD_REFRESH;
            3'h6: c = sdcba_pkg::CMD_BURST_STOP;
            default: c = sdcba_pkg::CMD_NOP;
         endcase
      end
      return c;
   endfunction

   function automatic logic [7:0] wrap_of(input logic [2:0] code);
      logic [7:0] m;
      case (code)
         sdcba_pkg::BL_CODE_2: m = 8'h01;
         sdcba_pkg::BL_CODE_4: m = 8'h03;
         sdcba_pkg::BL_CODE_8: m = 8'h07;
         sdcba_pkg::BL_CODE_PAGE: m = 8'hFF;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // Pins are sampled only at the rising edge; the decode below is combinational and feeds only registered state.
   assign cmd = decode(CHIP_SEL_B_IN, ROW_STROBE_B_IN, COL_STROBE_B_IN, WRITE_EN_B_IN);
   assign cl3 = (s.mode_reg[sdcba_pkg::MR_CL_LSB +: 3] == sdcba_pkg::CL_CODE_3);
   assign load_valid = (s.mode == sdcba_pkg::PWR_NORMAL) && (cl3 ? s.pipe_valid[1] : s.pipe_valid[0]);
   assign load_idx = cl3 ? s.pipe_idx[1] : s.pipe_idx[0];
   assign load_word = mem[load_idx];
   // The array has one port: a read-out cycle stalls the write drain.
   assign drain_ready = !load_valid;

   always_comb begin
      logic idle_cmd;
      logic all_idle;
      logic any_active;
      logic beat_on;
      logic beat_wr;
      logic [9:0] beat_idx;
      logic [7:0] wrap;
      logic [1:0] ba;
      next_s = s;
      idle_cmd = (cmd == sdcba_pkg::CMD_DESELECT) || (cmd == sdcba_pkg::CMD_NOP);
      all_idle = 1'b1;
      any_active = 1'b0;
      beat_on = 1'b0;
      beat_wr = 1'b0;
      beat_idx = '0;
      wrap = wrap_of(s.mode_reg[sdcba_pkg::MR_BL_LSB +: 3]);
      ba = BANK_ADDRESS_IN;
      push_valid = 1'b0;
      push_word = '0;
      next_s.refused = 1'b0;
      next_s.refreshed = 1'b0;
      next_s.wr_ready = fifo_in_ready;
      next_s.cke_low_prev = !CLOCK_EN_IN;
      for (int b = 0; b < sdcba_pkg::BANKS; b++) begin
         all_idle = all_idle && (s.bank[b] == sdcba_pkg::BANK_IDLE);
         any_active = any_active || (s.bank[b] == sdcba_pkg::BANK_ACTIVE);
         if (s.bank[b] == sdcba_pkg::BANK_CLOSING) begin
            if (s.close_cnt[b] <= 3'h1) begin
               next_s.bank[b] = sdcba_pkg::BANK_IDLE;
               next_s.close_cnt[b] = 3'h0;
            end else begin
               next_s.close_cnt[b] = 3'(s.close_cnt[b] - 3'h1);
            end
         end
      end
      case (s.mode)
         sdcba_pkg::PWR_NORMAL: begin
            if (s.burst_on) begin
               beat_on = 1'b1;
               beat_wr = s.burst_write;
               beat_idx = {s.burst_bank, s.burst_col};
               next_s.burst_col = (s.burst_col & ~s.burst_wrap) | (8'(s.burst_col + 8'h01) & s.burst_wrap);
               if (!s.burst_full) begin
                  next_s.beats_left = 8'(s.beats_left - 8'h01);
                  if (s.beats_left == 8'h01) begin
                     next_s.burst_on = 1'b0;
                     if (s.burst_ap) begin
                        next_s.bank[s.burst_bank] = sdcba_pkg::BANK_CLOSING;
                        next_s.close_cnt[s.burst_bank] = sdcba_pkg::PRECHARGE_CYC;
                     end
                  end
               end
            end
            case (cmd)
               sdcba_pkg::CMD_ACTIVATE: begin
                  if (s.bank[ba] == sdcba_pkg::BANK_IDLE) begin
                     next_s.bank[ba] = sdcba_pkg::BANK_ACTIVE;
                     next_s.open_row[ba] = ADDR_IN;
                  end else begin
                     next_s.refused = 1'b1;
                  end
               end
               sdcba_pkg::CMD_PRECHARGE: begin
                  for (int b = 0; b < sdcba_pkg::BANKS; b++) begin
                     if ((ADDR_IN[sdcba_pkg::AUTO_PRECHARGE_BIT] || (b == int'(ba)))
                         && (s.bank[b] == sdcba_pkg::BANK_ACTIVE)) begin
                        next_s.bank[b] = sdcba_pkg::BANK_CLOSING;
                        next_s.close_cnt[b] = sdcba_pkg::PRECHARGE_CYC;
                     end
                  end
                  if (s.burst_on && (ADDR_IN[sdcba_pkg::AUTO_PRECHARGE_BIT] || (s.burst_bank == ba))) begin
                     next_s.burst_on = 1'b0;
                     beat_on = 1'b0;
                  end
               end
               sdcba_pkg::CMD_READ, sdcba_pkg::CMD_WRITE: begin
                  if (s.bank[ba] == sdcba_pkg::BANK_ACTIVE) begin
                     beat_on = 1'b1;
                     beat_wr = (cmd == sdcba_pkg::CMD_WRITE);
                     beat_idx = {ba, ADDR_IN[sdcba_pkg::COL_W-1:0]};
                     next_s.burst_write = beat_wr;
                     next_s.burst_bank = ba;
                     next_s.burst_wrap = wrap;
                     next_s.burst_full = (wrap == 8'hFF);
                     next_s.burst_ap = ADDR_IN[sdcba_pkg::AUTO_PRECHARGE_BIT] && (wrap != 8'hFF);
                     next_s.burst_col = (ADDR_IN[7:0] & ~wrap) | (8'(ADDR_IN[7:0] + 8'h01) & wrap);
                     next_s.beats_left = wrap;
                     next_s.burst_on = (wrap != 8'h00);
                     if ((wrap == 8'h00) && ADDR_IN[sdcba_pkg::AUTO_PRECHARGE_BIT]) begin
                        next_s.bank[ba] = sdcba_pkg::BANK_CLOSING;
                        next_s.close_cnt[ba] = sdcba_pkg::PRECHARGE_CYC;
                     end
                  end else begin
                     next_s.refused = 1'b1;
                  end
               end
               sdcba_pkg::CMD_MODE_SET: begin
                  if (all_idle && !s.burst_on) begin
                     next_s.mode_reg = {BANK_ADDRESS_IN, ADDR_IN};
                  end else begin
                     next_s.refused = 1'b1;
                  end
               end
               sdcba_pkg::CMD_REFRESH: begin
                  if (all_idle && !s.burst_on) begin
                     if (CLOCK_EN_IN) begin
                        next_s.refreshed = 1'b1;
                     end else begin
                        next_s.mode = sdcba_pkg::PWR_SELF_REFRESH;
                     end
                  end else begin
                     next_s.refused = 1'b1;
                  end
               end
               sdcba_pkg::CMD_BURST_STOP: begin
                  if (s.burst_on) begin
                     next_s.burst_on = 1'b0;
                     beat_on = 1'b0;
                  end else begin
                     next_s.refused = 1'b1;
                  end
               end
               default: begin
               end
            endcase
            if (!CLOCK_EN_IN && (next_s.mode != sdcba_pkg::PWR_SELF_REFRESH)) begin
               if (s.burst_on || next_s.burst_on || (any_active && !idle_cmd)) begin
                  next_s.mode = sdcba_pkg::PWR_SUSPEND;
               end else begin
                  next_s.mode = sdcba_pkg::PWR_POWER_DOWN;
               end
            end
            // Read data leaves the array two edges after its beat with CAS latency 3, one edge after it with any other latency code.
            next_s.pipe_valid = {s.pipe_valid[0], beat_on && !beat_wr};
            next_s.pipe_idx = {s.pipe_idx[0], beat_idx};
            next_s.dq_out = load_word;
            next_s.dq_oe = load_valid ? ~s.mask_prev : 2'h0;
            next_s.mask_prev = {UPPER_BYTE_MASK_IN, LOWER_BYTE_MASK_IN};
            // Write data is taken at the beat's own edge; no stored mask pattern applies.
            if (beat_on && beat_wr && !(UPPER_BYTE_MASK_IN && LOWER_BYTE_MASK_IN)) begin
               push_valid = 1'b1;
               push_word.index = beat_idx;
               push_word.data = DATA_LINES_IN;
               push_word.keep = ~{UPPER_BYTE_MASK_IN, LOWER_BYTE_MASK_IN};
            end
         end
         sdcba_pkg::PWR_SUSPEND: begin
            if (CLOCK_EN_IN) begin
               next_s.mode = sdcba_pkg::PWR_NORMAL;
            end
         end
         sdcba_pkg::PWR_SELF_REFRESH, sdcba_pkg::PWR_POWER_DOWN: begin
            next_s.dq_oe = 2'h0;
            next_s.pipe_valid = 2'h0;
            if (CLOCK_EN_IN && s.cke_low_prev && idle_cmd) begin
               next_s.mode = sdcba_pkg::PWR_NORMAL;
            end
         end
         default: begin
            next_s.mode = sdcba_pkg::PWR_NORMAL;
         end
      endcase
      for (int b = 0; b < sdcba_pkg::BANKS; b++) begin
         next_s.active_vec[b] = (next_s.bank[b] == sdcba_pkg::BANK_ACTIVE);
      end
   end

   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Drained writes update only the unmasked byte lanes.
   always_ff @(posedge MCLK_IN) begin
      if (drain_valid && drain_ready) begin
         if (drain_word.keep[0]) begin
            mem[drain_word.index][7:0] <= drain_word.data[7:0];
         end
         if (drain_word.keep[1]) begin
            mem[drain_word.index][15:8] <= drain_word.data[15:8];
         end
      end
   end

   sdcba_fifo #(
      .WIDTH(WR_W),
      .DEPTH(sdcba_pkg::FIFO_DEPTH)
   ) u_write_fifo (
      .clk_in(MCLK_IN),
      .rst_b_in(RST_B_IN),
      .in_valid_in(push_valid),
      .in_data_in(push_word),
      .in_ready_out(fifo_in_ready),
      .out_valid_out(drain_valid),
      .out_data_out(drain_word),
      .out_ready_in(drain_ready)
   );

   assign DATA_LINES_OUT = s.dq_out;
   assign DATA_LINES_OE_OUT = s.dq_oe;
   assign BANK_ACTIVE_OUT = s.active_vec;
   assign POWER_MODE_OUT = s.mode;
   assign BURST_BUSY_OUT = s.burst_on;
   assign CMD_REFUSED_OUT = s.refused;
   assign AUTO_REFRESH_OUT = s.refreshed;
   assign WRITE_READY_OUT = s.wr_ready;
endmodule // sdcba_top

`default_nettype wire

// ### hw/sdcba_pkg.sv
// Shared constants, enumerations and carriers of the SDRAM command and bank-activate block.
package sdcba_pkg;

   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_MHZ = 200;
   localparam int T_PRECHARGE_NS = 20;
   localparam int PRECHARGE_CYC_INT = (T_PRECHARGE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [2:0] PRECHARGE_CYC = 3'(PRECHARGE_CYC_INT);

   // ****************************************
   // Widths and field positions
   // ****************************************
   localparam int BANKS = 4;
   localparam int ADDR_W = 12;
   localparam int COL_W = 8;
   localparam int DATA_W = 16;
   localparam int IDX_W = 10;
   localparam int AUTO_PRECHARGE_BIT = 10;
   localparam int MR_W = 14;
   localparam int MR_BL_LSB = 0;
   localparam int MR_CL_LSB = 4;
   localparam logic [2:0] BL_CODE_1 = 3'h0;
   localparam logic [2:0] BL_CODE_2 = 3'h1;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] BL_CODE_PAGE = 3'h7;
   localparam logic [2:0] CL_CODE_3 = 3'h3;
   localparam int FIFO_DEPTH = 8;

   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [3:0] {
      CMD_DESELECT = 4'h0, CMD_NOP = 4'h1, CMD_ACTIVATE = 4'h2, CMD_PRECHARGE = 4'h3, CMD_READ = 4'h4,
      CMD_WRITE = 4'h5, CMD_MODE_SET = 4'h6, CMD_REFRESH = 4'h7, CMD_BURST_STOP = 4'h8
   } sdcba_cmd_t;

   typedef enum logic [1:0] {
      PWR_NORMAL = 2'h0, PWR_SELF_REFRESH = 2'h1, PWR_POWER_DOWN = 2'h2, PWR_SUSPEND = 2'h3
   } sdcba_pwr_t;

   typedef enum logic [1:0] {BANK_IDLE = 2'h0, BANK_ACTIVE = 2'h1, BANK_CLOSING = 2'h2} sdcba_bank_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [IDX_W-1:0] index;
      logic [DATA_W-1:0] data;
      logic [1:0] keep;
   } sdcba_wr_t;

endpackage

// ### tb/sdcba_ctrl_model.sv
// Memory controller model that drives commands, masks and write data into the device.
`timescale 1ns/1ps
`default_nettype none
module sdcba_ctrl_model (
   // Clock.
   input wire logic clk_in,
   // Command, address, mask and data pins.
   output logic cke_out,
   output logic [3:0] pins_out,
   output logic [1:0] bank_out,
   output logic [11:0] addr_out,
   output logic [1:0] mask_out,
   output logic [15:0] data_out
);
   initial begin
      cke_out = 1'b1;
      pins_out = 4'hF;
      bank_out = 2'h0;
      addr_out = 12'h000;
      mask_out = 2'h0;
      data_out = 16'h0000;
   end
   // Pins change after the falling edge and hold across the capturing rising edge.
   task automatic cmd(input logic [3:0] p, input logic [1:0] b, input logic [11:0] a, input logic ce,
      input logic [1:0] m, input logic wr, input logic [15:0] d);
      @(negedge clk_in);
      pins_out = p;
      bank_out = b;
      addr_out = a;
      cke_out = ce;
      mask_out = m;
      data_out = wr ? d : ~data_out;
      @(posedge clk_in);
      #1;
   endtask
   // Waiting time is spent issuing no-operation commands.
   task automatic wait_nop(input int n);
      repeat (n) cmd(4'h7, 2'h0, 12'h000, 1'b1, 2'h0, 1'b0, 16'h0000);
   endtask
endmodule // sdcba_ctrl_model
`default_nettype wire

// ### tb/sdcba_top_checker.sv
// Concurrent checks on the ports of the SDRAM command and bank-activate block.
`timescale 1ns/1ps
`default_nettype none
module sdcba_top_checker (
   // Clock, reset and command pins.
   input wire logic MCLK_IN,
   input wire logic RST_B_IN,
   input wire logic CLOCK_EN_IN,
   input wire logic CHIP_SEL_B_IN,
   input wire logic ROW_STROBE_B_IN,
   input wire logic COL_STROBE_B_IN,
   input wire logic WRITE_EN_B_IN,
   input wire logic [1:0] BANK_ADDRESS_IN,
   input wire logic [11:0] ADDR_IN,
   // Status.
   input wire logic [1:0] DATA_LINES_OE_OUT,
   input wire logic [3:0] BANK_ACTIVE_OUT,
   input wire logic [1:0] POWER_MODE_OUT,
   input wire logic BURST_BUSY_OUT,
   input wire logic CMD_REFUSED_OUT,
   input wire logic AUTO_REFRESH_OUT
);
   wire [2:0] pin = {ROW_STROBE_B_IN, COL_STROBE_B_IN, WRITE_EN_B_IN};
   wire sel = !CHIP_SEL_B_IN;
   wire run = POWER_MODE_OUT == 2'h0;
   wire act = run && sel && pin == 3'h3;
   wire pre = run && sel && pin == 3'h2;
   wire acc = run && sel && pin[2:1] == 2'h2;
   wire stop = run && sel && pin == 3'h6;
   wire calm = !sel || pin == 3'h7;
   wire auto_go = run && sel && pin == 3'h1 && CLOCK_EN_IN;
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RST_B_IN);
   a_act_busy_bank: assert property (act && BANK_ACTIVE_OUT[BANK_ADDRESS_IN] |=> CMD_REFUSED_OUT)
      else $error("activate of an open bank not refused");
   a_act_opens_bank: assert property (act |=> CMD_REFUSED_OUT || BANK_ACTIVE_OUT[$past(BANK_ADDRESS_IN)])
      else $error("activate did not open the bank");
   a_access_idle_bank: assert property (acc && !BANK_ACTIVE_OUT[BANK_ADDRESS_IN] |=> CMD_REFUSED_OUT)
      else $error("access to a closed bank not refused");
   a_close_one_bank: assert property (pre && !ADDR_IN[10] |=> !BANK_ACTIVE_OUT[$past(BANK_ADDRESS_IN)])
      else $error("precharge left the bank active");
   a_stop_no_burst: assert property (stop && !BURST_BUSY_OUT |=> CMD_REFUSED_OUT)
      else $error("burst stop without a burst not refused");
   a_refresh_cause: assert property (AUTO_REFRESH_OUT |-> $past(auto_go) && BANK_ACTIVE_OUT == 4'h0)
      else $error("auto refresh without its command");
   a_power_down_entry: assert property (run && calm && !CLOCK_EN_IN && !BURST_BUSY_OUT |=> POWER_MODE_OUT == 2'h2)
      else $error("power down not entered");
   a_burst_suspends: assert property (run && calm && !CLOCK_EN_IN && BURST_BUSY_OUT |=> POWER_MODE_OUT == 2'h3)
      else $error("power down during a burst did not suspend");
   a_wake_up: assert property (^POWER_MODE_OUT && calm && CLOCK_EN_IN && !$past(CLOCK_EN_IN) |=> run)
      else $error("low power mode not left");
   a_suspend_exit: assert property (POWER_MODE_OUT == 2'h3 && CLOCK_EN_IN |=> run)
      else $error("clock suspend not left");
   a_low_power_quiet: assert property (^POWER_MODE_OUT && $past(^POWER_MODE_OUT) |-> DATA_LINES_OE_OUT == 2'h0)
      else $error("data lines driven in low power mode");
endmodule // sdcba_top_checker
bind sdcba_top sdcba_top_checker sdcba_top_checker_i (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN), .CLOCK_EN_IN(CLOCK_EN_IN),
   .CHIP_SEL_B_IN(CHIP_SEL_B_IN), .ROW_STROBE_B_IN(ROW_STROBE_B_IN), .COL_STROBE_B_IN(COL_STROBE_B_IN),
   .WRITE_EN_B_IN(WRITE_EN_B_IN), .BANK_ADDRESS_IN(BANK_ADDRESS_IN), .ADDR_IN(ADDR_IN),
   .DATA_LINES_OE_OUT(DATA_LINES_OE_OUT), .BANK_ACTIVE_OUT(BANK_ACTIVE_OUT), .POWER_MODE_OUT(POWER_MODE_OUT),
   .BURST_BUSY_OUT(BURST_BUSY_OUT), .CMD_REFUSED_OUT(CMD_REFUSED_OUT), .AUTO_REFRESH_OUT(AUTO_REFRESH_OUT));
`default_nettype wire

// ### tb/test_sdcba_top.sv
// Self-checking testbench of the SDRAM command and bank-activate block.
`timescale 1ns/1ps
`default_nettype none
module test_sdcba_top;
   localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4, MRS = 4'h0, REF = 4'h1, BST = 4'h6;
   // Controller delays in clock cycles.
   localparam int RCD = 3, RRD = 2, RC = 12;
   logic clk;
   logic rst_b;
   logic cke;
   logic [3:0] pins;
   logic [1:0] bank;
   logic [11:0] addr;
   logic [1:0] mask;
   logic [15:0] dq_in;
   logic [15:0] dq_out;
   logic [1:0] oe;
   logic [3:0] act_st;
   logic [1:0] pwr;
   logic busy, refused, aref, wready;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   sdcba_ctrl_model sdcba_ctrl_model_i (.clk_in(clk), .cke_out(cke), .pins_out(pins), .bank_out(bank), .addr_out(addr),
      .mask_out(mask), .data_out(dq_in));
   sdcba_top sdcba_top_i (.MCLK_IN(clk), .RST_B_IN(rst_b), .CLOCK_EN_IN(cke), .CHIP_SEL_B_IN(pins[3]),
      .ROW_STROBE_B_IN(pins[2]), .COL_STROBE_B_IN(pins[1]), .WRITE_EN_B_IN(pins[0]), .BANK_ADDRESS_IN(bank),
      .ADDR_IN(addr), .LOWER_BYTE_MASK_IN(mask[0]), .UPPER_BYTE_MASK_IN(mask[1]), .DATA_LINES_IN(dq_in),
      .DATA_LINES_OUT(dq_out), .DATA_LINES_OE_OUT(oe), .BANK_ACTIVE_OUT(act_st), .POWER_MODE_OUT(pwr),
      .BURST_BUSY_OUT(busy), .CMD_REFUSED_OUT(refused), .AUTO_REFRESH_OUT(aref), .WRITE_READY_OUT(wready));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   task automatic go(input logic [3:0] p, input logic [1:0] b, input logic [11:0] a, input logic ce);
      sdcba_ctrl_model_i.cmd(p, b, a, ce, 2'h0, 1'b0, 16'h0000);
   endtask
   task automatic idle(input int n);
      sdcba_ctrl_model_i.wait_nop(n);
   endtask
   task automatic tally_and_finish;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic test_banks;
      go(ACT, 2'h1, 12'hABC, 1'b1);
      chk("bank1 open", 16'h0002, 16'(act_st));
      idle(RC);
      go(ACT, 2'h1, 12'h123, 1'b1);
      chk("reopen refused", 16'h0001, 16'(refused));
      go(RD, 2'h3, 12'h000, 1'b1);
      chk("idle read refused", 16'h0001, 16'(refused));
      go(PRE, 2'h1, 12'h000, 1'b1);
      chk("bank1 closed", 16'h0000, 16'(act_st));
      idle(RC);
      go(ACT, 2'h2, 12'h001, 1'b1);
      idle(RRD);
      go(ACT, 2'h3, 12'h002, 1'b1);
      chk("banks 2 3 open", 16'h000C, 16'(act_st));
      go(PRE, 2'h0, 12'h400, 1'b1);
      chk("all closed", 16'h0000, 16'(act_st));
      idle(8);
   endtask
   task automatic test_data;
      go(MRS, 2'h0, 12'h021, 1'b1);
      go(ACT, 2'h0, 12'h010, 1'b1);
      idle(RCD);
      sdcba_ctrl_model_i.cmd(WR, 2'h0, 12'h002, 1'b1, 2'h2, 1'b1, 16'hA55A);
      sdcba_ctrl_model_i.cmd(NOP, 2'h0, 12'h000, 1'b1, 2'h0, 1'b1, 16'h3CC3);
      idle(10);
      sdcba_ctrl_model_i.cmd(RD, 2'h0, 12'h002, 1'b1, 2'h2, 1'b0, 16'h0000);
      idle(1);
      chk("beat0 lanes", 16'h0001, 16'(oe));
      chk("beat0 low byte", 16'h005A, {8'h00, dq_out[7:0]});
      idle(1);
      chk("beat1 lanes", 16'h0003, 16'(oe));
      chk("beat1 word", 16'h3CC3, dq_out);
      idle(1);
      chk("lanes released", 16'h0000, 16'(oe));
      go(BST, 2'h0, 12'h000, 1'b1);
      chk("idle stop", 16'h0001, 16'(refused));
      go(RD, 2'h0, 12'h003, 1'b1);
      go(BST, 2'h0, 12'h000, 1'b1);
      chk("stop taken", 16'h0000, 16'(refused));
      idle(4);
   endtask
   task automatic test_power;
      go(REF, 2'h0, 12'h000, 1'b1);
      chk("refresh refused", 16'h0001, 16'(refused));
      go(PRE, 2'h0, 12'h400, 1'b1);
      idle(6);
      go(REF, 2'h0, 12'h000, 1'b1);
      chk("auto refresh", 16'h0001, 16'(aref));
      go(NOP, 2'h0, 12'h000, 1'b0);
      chk("power down", 16'h0002, 16'(pwr));
      go(NOP, 2'h0, 12'h000, 1'b1);
      chk("power up", 16'h0000, 16'(pwr));
      go(REF, 2'h0, 12'h000, 1'b0);
      go(NOP, 2'h0, 12'h000, 1'b0);
      chk("self refresh", 16'h0001, 16'(pwr));
      go(NOP, 2'h0, 12'h000, 1'b1);
      chk("self refresh exit", 16'h0000, 16'(pwr));
      go(ACT, 2'h0, 12'h020, 1'b1);
      idle(RCD);
      go(RD, 2'h0, 12'h002, 1'b0);
      chk("suspend", 16'h0003, 16'(pwr));
      go(NOP, 2'h0, 12'h000, 1'b1);
      chk("resume", 16'h0000, 16'(pwr));
      idle(4);
      go(RD, 2'h0, 12'h002, 1'b1);
      go(NOP, 2'h0, 12'h000, 1'b0);
      chk("burst suspend", 16'h0003, 16'(pwr));
      go(NOP, 2'h0, 12'h000, 1'b1);
      chk("burst resume", 16'h0000, 16'(pwr));
      idle(4);
      go(PRE, 2'h0, 12'h400, 1'b1);
      idle(6);
      go(MRS, 2'h0, 12'h030, 1'b1);
      go(ACT, 2'h0, 12'h030, 1'b1);
      idle(RCD);
      go(RD, 2'h0, 12'h003, 1'b1);
      idle(1);
      chk("cl3 early lanes", 16'h0000, 16'(oe));
      idle(1);
      chk("cl3 lanes", 16'h0003, 16'(oe));
      chk("cl3 word", 16'h3CC3, dq_out);
      idle(4);
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      @(posedge clk);
      #1;
      chk("write ready", 16'h0001, 16'(wready));
      test_banks();
      test_data();
      test_power();
      tally_and_finish();
   end
endmodule // test_sdcba_top
`default_nettype wire
